// [core/cpg_regs.sv]
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module cpg_regs
    import cpg_pkg::*;
#(
    parameter int TICK_CYCLES = RING_STEP_CYC
)(
    // Clock and reset
    input  wire logic               core_clk,
    input  wire logic               resetn,
    // Avalon-MM slave
    input  wire logic [7:0]         address,
    input  wire logic               read,
    input  wire logic               write,
    input  wire logic [31:0]        writedata,
    output logic      [31:0]        readdata,
    output logic                    waitrequest,
    // Monitor samples
    input  wire logic signed [15:0] rx_sample,
    input  wire logic signed [15:0] tx_sample,
    input  wire logic               sample_valid,
    output logic signed [15:0]      call_progress_monitor_out,
    // Ring validation
    input  wire logic               ring_event,
    output logic                    ring_valid,
    output logic                    ring_invalid
);

    // ---------------------------------------------------------------
    // Bus slave: one wait state, then answer
    // ---------------------------------------------------------------
    logic        ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic [7:0]  rx_gain_q, rx_gain_d, tx_gain_q, tx_gain_d;
    logic [7:0]  ring_ctrl_q, ring_ctrl_d, ring_ext_q, ring_ext_d;
    logic [5:0]  idx;
    logic        req, wr_go;

    assign idx         = address[7:2];
    assign req         = read | write;
    assign waitrequest = req & ~ack_q;
    assign wr_go       = write & ack_q;
    assign readdata    = rdata_q;

    always_comb
    begin
        ack_d       = req & ~ack_q;
        rdata_d     = rdata_q;
        rx_gain_d   = rx_gain_q;
        tx_gain_d   = tx_gain_q;
        ring_ctrl_d = ring_ctrl_q;
        ring_ext_d  = ring_ext_q;
        if (read & ~ack_q)
        begin
            // Unmapped addresses read as zero
            case (idx)
                RX_GAIN_IDX:   rdata_d = {24'h000000, rx_gain_q};
                TX_GAIN_IDX:   rdata_d = {24'h000000, tx_gain_q};
                RING_CTRL_IDX: rdata_d = {24'h000000, ring_ctrl_q};
                RING_EXT_IDX:  rdata_d = {24'h000000, 7'h00, ring_ext_q[0]};
                default:       rdata_d = 32'h00000000;
            endcase
        end
        if (wr_go)
        begin
            case (idx)
                RX_GAIN_IDX:   rx_gain_d   = writedata[7:0];
                TX_GAIN_IDX:   tx_gain_d   = writedata[7:0];
                RING_CTRL_IDX: ring_ctrl_d = writedata[7:0];
                RING_EXT_IDX:  ring_ext_d  = {7'h00, writedata[0]};
                default:       ;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ack_q       <= 1'b0;
            rdata_q     <= 32'h00000000;
            rx_gain_q   <= RX_GAIN_RST;
            tx_gain_q   <= TX_GAIN_RST;
            ring_ctrl_q <= RING_CTRL_RST;
            ring_ext_q  <= RING_EXT_RST;
        end
        else
        begin
            ack_q       <= ack_d;
            rdata_q     <= rdata_d;
            rx_gain_q   <= rx_gain_d;
            tx_gain_q   <= tx_gain_d;
            ring_ctrl_q <= ring_ctrl_d;
            ring_ext_q  <= ring_ext_d;
        end
    end

    // ---------------------------------------------------------------
    // Monitor gain: code/64 per path, saturated sum
    // ---------------------------------------------------------------
    logic signed [24:0] rx_prod, tx_prod;
    logic signed [18:0] rx_term, tx_term;
    logic signed [19:0] mon_sum;
    logic signed [15:0] mon_q, mon_d;

    assign rx_prod = rx_sample * $signed({1'b0, rx_gain_q});
    assign tx_prod = tx_sample * $signed({1'b0, tx_gain_q});
    // Explicit mute so a zero code never leaks rounding residue
    assign rx_term = (rx_gain_q == 8'h00) ? 19'sh00000
                                          : rx_prod[24:GAIN_SHIFT];
    assign tx_term = (tx_gain_q == 8'h00) ? 19'sh00000
                                          : tx_prod[24:GAIN_SHIFT];
    assign mon_sum = 20'(rx_term) + 20'(tx_term);

    always_comb
    begin
        mon_d = mon_q;
        if (sample_valid)
        begin
            // Up to +12 dB per path can overflow 16 bits, so clip
            if (mon_sum > 20'sh07FFF)
                mon_d = 16'sh7FFF;
            else if (mon_sum < -20'sh08000)
                mon_d = -16'sh8000;
            else
                mon_d = mon_sum[15:0];
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            mon_q <= 16'sh0000;
        else
            mon_q <= mon_d;
    end

    assign call_progress_monitor_out = mon_q;

    // ---------------------------------------------------------------
    // Ring validation engine
    // ---------------------------------------------------------------
    logic [5:0]     ring_period_limit;
    logic [2:0]     ring_assert_delay;
    logic [16:0]    div_q, div_d;
    logic           tick;
    logic [6:0]     per_q, per_d;
    logic [9:0]     dly_q, dly_d;
    logic [9:0]     dly_target;
    logic           inv_q, inv_d;
    logic           too_slow;
    cpg_ring_t      st_q, st_d;

    assign ring_period_limit = ring_ctrl_q[LIMIT_W-1:0];
    assign ring_assert_delay = {ring_ext_q[0], ring_ctrl_q[DLY_LSB+1:DLY_LSB]};
    assign tick       = (div_q == 17'(TICK_CYCLES - 1));
    assign too_slow   = (per_q > {1'b0, ring_period_limit});
    assign dly_target = 10'(ring_assert_delay * DELAY_STEP_TK);

    always_comb
    begin
        div_d = tick ? 17'h00000 : div_q + 17'h00001;
        per_d = per_q;
        dly_d = dly_q;
        inv_d = 1'b0;
        st_d  = st_q;
        // 2 ms timer restarts on each event and saturates past any limit
        if (ring_event)
            per_d = 7'h00;
        else if (tick && per_q != 7'h7F)
            per_d = per_q + 7'h01;
        case (st_q)
            RING_IDLE:
                if (ring_event)
                    st_d = RING_QUAL;
            RING_QUAL, RING_DELAY, RING_VALID:
            begin
                if (too_slow)
                begin
                    inv_d = 1'b1;
                    st_d  = RING_IDLE;
                end
                else if (st_q == RING_QUAL && ring_event)
                begin
                    dly_d = 10'h000;
                    st_d  = (dly_target == 10'h000) ? RING_VALID : RING_DELAY;
                end
                else if (st_q == RING_DELAY)
                begin
                    if (tick)
                        dly_d = dly_q + 10'h001;
                    if (dly_q >= dly_target)
                        st_d = RING_VALID;
                end
            end
            default:
                st_d = RING_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            div_q <= 17'h00000;
            per_q <= 7'h00;
            dly_q <= 10'h000;
            inv_q <= 1'b0;
            st_q  <= RING_IDLE;
        end
        else
        begin
            div_q <= div_d;
            per_q <= per_d;
            dly_q <= dly_d;
            inv_q <= inv_d;
            st_q  <= st_d;
        end
    end

    assign ring_valid   = (st_q == RING_VALID);
    assign ring_invalid = inv_q;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence s_write_done;
        write && !waitrequest;
    endsequence

    sequence s_read_done;
        read && !waitrequest;
    endsequence

    property p_rx_unity;
        sample_valid && rx_gain_q == GAIN_UNITY && tx_gain_q == 8'h00
            |=> mon_q == $past(rx_sample);
    endproperty
    a_rx_unity: assert property (p_rx_unity) else $error("rx unity gain wrong");

    property p_rx_mute;
        sample_valid && rx_gain_q == 8'h00 && tx_gain_q == 8'h00 |=> mon_q == 16'sh0000;
    endproperty
    a_rx_mute: assert property (p_rx_mute) else $error("rx mute leaks");

    property p_tx_unity;
        sample_valid && tx_gain_q == GAIN_UNITY && rx_gain_q == 8'h00
            |=> mon_q == $past(tx_sample);
    endproperty
    a_tx_unity: assert property (p_tx_unity) else $error("tx unity gain wrong");

    // Half receive gain with transmit muted: output must ignore the transmit sample
    property p_tx_mute;
        sample_valid && tx_gain_q == 8'h00 && rx_gain_q == 8'h20
            |=> mon_q == ($past(rx_sample) >>> 1);
    endproperty
    a_tx_mute: assert property (p_tx_mute) else $error("tx mute leaks");

    property p_ring_write;
        s_write_done and (idx == RING_CTRL_IDX)
            |=> ring_period_limit == $past(writedata[5:0])
                && ring_assert_delay[1:0] == $past(writedata[7:6]);
    endproperty
    a_ring_write: assert property (p_ring_write) else $error("ring fields wrong");

    property p_zero_delay;
        st_q == RING_QUAL && ring_event && !too_slow && dly_target == 10'h000
            |=> ring_valid;
    endproperty
    a_zero_delay: assert property (p_zero_delay) else $error("zero delay not immediate");

    property p_invalid;
        st_q != RING_IDLE && too_slow |=> ring_invalid && !ring_valid;
    endproperty
    a_invalid: assert property (p_invalid) else $error("slow ring not invalidated");

    property p_readback;
        s_read_done and (idx == RX_GAIN_IDX) |-> readdata == {24'h000000, rx_gain_q};
    endproperty
    a_readback: assert property (p_readback) else $error("readback mismatch");

    property p_answer;
        req |-> ##[0:1] !waitrequest;
    endproperty
    a_answer: assert property (p_answer) else $error("bus answer late");

endmodule : cpg_regs
`default_nettype wire

// [core/cpg_pkg.sv]
// What this block does
// - Receive monitor term scales by code over 64
// - Receive code zero mutes receive term
// - Transmit monitor term scales by code over 64
// - Transmit code zero mutes transmit term
// - Ring register: delay top two, limit low six
// - Three delay bits select 256 ms steps
// - Ring invalid when 2 ms timer exceeds limit
`default_nettype none
package cpg_pkg;

    // ---------------------------------------------------------------
    // Register map (index, byte address is four times the index)
    // ---------------------------------------------------------------
    localparam logic [5:0] RX_GAIN_IDX   = 6'h14;
    localparam logic [5:0] TX_GAIN_IDX   = 6'h15;
    localparam logic [5:0] RING_CTRL_IDX = 6'h16;
    localparam logic [5:0] RING_EXT_IDX  = 6'h17;

    // ---------------------------------------------------------------
    // Reset values and field layout
    // ---------------------------------------------------------------
    localparam logic [7:0] RX_GAIN_RST   = 8'h00;
    localparam logic [7:0] TX_GAIN_RST   = 8'h00;
    localparam logic [7:0] RING_CTRL_RST = 8'h96;
    localparam logic [7:0] RING_EXT_RST  = 8'h00;
    localparam int         DLY_LSB       = 6;
    localparam int         LIMIT_W       = 6;
    localparam int         GAIN_SHIFT    = 6;
    localparam logic [7:0] GAIN_UNITY    = 8'h40;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_KHZ        = 40000;
    localparam int RING_STEP_US   = 2000;
    localparam int DELAY_STEP_MS  = 256;
    localparam int RING_STEP_CYC  = (RING_STEP_US * CLK_KHZ) / 1000;
    localparam int DELAY_STEP_TK  = (DELAY_STEP_MS * 1000) / RING_STEP_US;

    typedef enum logic [1:0] {
        RING_IDLE  = 2'b00,
        RING_QUAL  = 2'b01,
        RING_DELAY = 2'b11,
        RING_VALID = 2'b10
    } cpg_ring_t;

endpackage : cpg_pkg
`default_nettype wire

// [tb/test_call_progress_gain_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module test_call_progress_gain_regs
    import cpg_pkg::*;
;
    // ---------------------------------------------------------------
    // Stimulus and instance
    // ---------------------------------------------------------------
    localparam int TICKS = 4;
    logic               core_clk     = 1'b0;
    logic               resetn       = 1'b0;
    logic [7:0]         address      = 8'h00;
    logic               read         = 1'b0;
    logic               write        = 1'b0;
    logic [31:0]        writedata    = 32'h0;
    logic [31:0]        readdata;
    logic               waitrequest;
    logic signed [15:0] rx_sample    = 16'h0;
    logic signed [15:0] tx_sample    = 16'h0;
    logic               sample_valid = 1'b0;
    logic signed [15:0] call_progress_monitor_out;
    logic               ring_event   = 1'b0;
    logic               ring_valid;
    logic               ring_invalid;
    logic [31:0]        rd;
    logic [7:0]         codes [6]    = '{8'h00, 8'h10, 8'h20, 8'h40, 8'h7F, 8'hFF};
    int                 failures     = 0;
    int                 compares     = 0;

    always #12.5 core_clk = ~core_clk;

    cpg_regs #(.TICK_CYCLES(TICKS)) cpg_regs_inst (
        .core_clk                  (core_clk),
        .resetn                    (resetn),
        .address                   (address),
        .read                      (read),
        .write                     (write),
        .writedata                 (writedata),
        .readdata                  (readdata),
        .waitrequest               (waitrequest),
        .rx_sample                 (rx_sample),
        .tx_sample                 (tx_sample),
        .sample_valid              (sample_valid),
        .call_progress_monitor_out (call_progress_monitor_out),
        .ring_event                (ring_event),
        .ring_valid                (ring_valid),
        .ring_invalid              (ring_invalid)
    );

    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task end_sim;
        $display("Counts: %0d compares, %0d failures", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Request held until waitrequest is seen low at a rising edge
    task bus(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        int i;
        @(posedge core_clk);
        address   <= addr;
        writedata <= wd;
        read      <= !wr;
        write     <= wr;
        for (i = 0; i < 50; i++)
        begin
            @(posedge core_clk);
            if (waitrequest === 1'b0) break;
        end
        rd = readdata;
        read  <= 1'b0;
        write <= 1'b0;
        if (i == 50)
        begin
            failures++;
            end_sim();
        end
    endtask : bus

    // Floor shift per path, then clip to the 16-bit output range
    function logic [15:0] mexp(input int rx, input int tx, input int rc, input int tc);
        int s;
        s = ((rx * rc) >>> 6) + ((tx * tc) >>> 6);
        if (s > 32767) s = 32767;
        if (s < -32768) s = -32768;
        return s[15:0];
    endfunction : mexp

    task mon(input int rx, input int tx, input int rc, input int tc);
        bus(1'b1, 8'h50, 32'(rc));
        bus(1'b1, 8'h54, 32'(tc));
        @(posedge core_clk);
        rx_sample    <= 16'(rx);
        tx_sample    <= 16'(tx);
        sample_valid <= 1'b1;
        @(posedge core_clk);
        sample_valid <= 1'b0;
        @(posedge core_clk);
        check("monitor", {16'h0, call_progress_monitor_out}, {16'h0, mexp(rx, tx, rc, tc)});
    endtask : mon

    // Events every 8 cycles (2 ticks) keep the period under the limit of 10
    task ring_try(input int d);
        int n;
        int since;
        since = 0;
        bus(1'b1, 8'h5C, 32'(d >> 2));
        bus(1'b1, 8'h58, {24'h0, 2'(d), 6'h0A});
        for (n = 0; n < 4000; n++)
        begin
            @(posedge core_clk);
            if (ring_valid === 1'b1) break;
            ring_event <= (n % 8 == 0);
            since = (n % 8 == 0) ? 0 : since + 1;
        end
        check("valid delay", {31'h0, n >= 8 + d * 512 && n <= 32 + d * 512}, 1);
        if (n == 4000) end_sim();
        ring_event <= 1'b0;
        for (n = 0; n < 200; n++)
        begin
            @(posedge core_clk);
            since++;
            if (ring_invalid === 1'b1) break;
        end
        check("invalid time", {31'h0, since >= 40 && since <= 52}, 1);
        check("valid drop", {31'h0, ring_valid}, 0);
        if (n == 200) end_sim();
    endtask : ring_try

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial
    begin
        #2500000;
        failures++;
        end_sim();
    end

    initial
    begin
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        bus(1'b0, 8'h50, 32'h0);
        check("rx_monitor_gain reset", rd, 32'h00);
        bus(1'b0, 8'h54, 32'h0);
        check("tx_monitor_gain reset", rd, 32'h00);
        bus(1'b0, 8'h58, 32'h0);
        check("ring_validation_ctrl_one reset", rd, 32'h96);
        bus(1'b1, 8'h60, 32'hFF);
        bus(1'b0, 8'h60, 32'h0);
        check("unmapped", rd, 32'h0);
        bus(1'b0, 8'h5C, 32'h0);
        check("ring delay bit two reset", rd, 32'h00);
        bus(1'b1, 8'h5C, 32'hFF);
        bus(1'b0, 8'h5C, 32'h0);
        check("ring delay bit two", rd, 32'h01);
        $display("Reset value test done");
        foreach (codes[k])
        begin
            for (int a = 0; a < 3; a++) bus(1'b1, 8'(8'h50 + 4 * a), 32'(codes[k] ^ a));
            for (int a = 0; a < 3; a++)
            begin
                bus(1'b0, 8'(8'h50 + 4 * a), 32'h0);
                check("readback", rd, 32'(codes[k] ^ a));
            end
        end
        $display("Readback test done");
        foreach (codes[k])
        begin
            mon(-1001, 777, codes[k], 0);
            mon(-1001, 777, 0, codes[k]);
        end
        mon(32767, 32767, 255, 255);
        mon(-300, 500, 64, 16);
        $display("Monitor gain test done");
        ring_try(0);
        ring_try(1);
        ring_try(4);
        $display("Ring test done");
        end_sim();
    end
endmodule : test_call_progress_gain_regs
`default_nettype wire
